// *** eac_pkg.sv ***
package eac_pkg;
    localparam int EAC_ADDR_W = 12;
    localparam logic [11:0] EAC_CTRL_OFS = 12'h0a0;
    localparam logic [11:0] EAC_ADDR_DATA_OFS = 12'h0a4;
    localparam logic [11:0] EAC_INT_STAT_OFS = 12'h1f0;
    localparam logic [11:0] EAC_INT_MASK_OFS = 12'h1f4;
    // Control word layout
    localparam int EAC_START_BIT = 0;
    localparam int EAC_CMD_LSB = 1;
    localparam int EAC_AL_STAT_BIT = 4;
    localparam int EAC_AL_DIS_BIT = 5;
    localparam int EAC_RATE_LSB = 6;
    localparam int EAC_STAT_LSB = 8;
    localparam logic [15:0] EAC_CTRL_RST = 16'h0060;
    localparam logic [15:0] EAC_ADDR_RST = 16'h0000;
    localparam logic [15:0] EAC_DATA_RST = 16'h0000;
    // Bits 10, 11 and 15 of the control word are writable by software
    localparam logic [7:0] EAC_STAT_WR_MASK = 8'h8c;
    localparam logic [1:0] EAC_RATE_DIV64 = 2'h1;
    localparam logic [1:0] EAC_RATE_TEST = 2'h3;
    localparam int EAC_CORE_MHZ = 250;
    localparam int EAC_DIV_RATIO = 64;
    localparam logic [5:0] EAC_DIV64_HALF = 6'(EAC_DIV_RATIO / 2);
    localparam logic [5:0] EAC_TEST_HALF = 6'h02;
    localparam int EAC_FRAME_W = 40;
    localparam logic [5:0] EAC_BITS_OP = 6'h08;
    localparam logic [5:0] EAC_BITS_STAT = 6'h10;
    localparam logic [5:0] EAC_BITS_DATA = 6'h28;
    // Interrupt status bits
    localparam int EAC_INT_W = 2;
    localparam int EAC_INT_ACC = 0;
    localparam int EAC_INT_AL = 1;

    // Command codes equal the serial opcodes they send
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_WRSR = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_READ = 3'h3,
        CMD_WRDI = 3'h4,
        CMD_RDSR = 3'h5,
        CMD_WREN = 3'h6,
        CMD_BAD = 3'h7
    } eac_cmd_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_AL_SIG = 2'h1,
        ST_AL_WORD = 2'h3,
        ST_ACC = 2'h2
    } eac_state_e;

    typedef struct packed {
        logic vld;
        logic [15:0] addr;
        logic [15:0] data;
    } eac_cfg_s;
endpackage

// *** eac_shifter.sv ***
`timescale 1ns/100ps
`default_nettype none
module eac_shifter #(
    parameter int FRAME_W = 40,
    parameter int RX_W = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [FRAME_W-1:0] frame,
    input wire logic [5:0] nbits,
    input wire logic [5:0] half,
    output logic busy,
    output logic done,
    output logic [RX_W-1:0] rx,
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    import eac_pkg::*;

    if (FRAME_W > 63 || RX_W > FRAME_W || RX_W < 2) begin : g_chk
        $error("eac_shifter: unsupported widths");
    end

    logic busy_ff, done_ff, sck_ff;
    logic [FRAME_W-1:0] sh_ff;
    logic [RX_W-1:0] rx_ff;
    logic [5:0] cnt_ff, bits_ff, half_ff, hi_cnt_ff;

    // Mode 0: data change on the falling edge, sampled on the rising one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            sck_ff <= 1'b0;
            sh_ff <= '0;
            rx_ff <= '0;
            cnt_ff <= 6'h00;
            bits_ff <= 6'h00;
            half_ff <= 6'h01;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff) begin
                if (start) begin
                    busy_ff <= 1'b1;
                    sh_ff <= frame;
                    bits_ff <= nbits;
                    half_ff <= half;
                    cnt_ff <= 6'h00;
                end
            end else if (cnt_ff == half_ff - 6'h01) begin
                cnt_ff <= 6'h00;
                if (!sck_ff) begin
                    sck_ff <= 1'b1;
                    rx_ff <= {rx_ff[RX_W-2:0], miso};
                end else begin
                    sck_ff <= 1'b0;
                    sh_ff <= sh_ff << 1;
                    bits_ff <= bits_ff - 6'h01;
                    if (bits_ff == 6'h01) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end
            end else begin
                cnt_ff <= cnt_ff + 6'h01;
            end
        end
    end

    // Counts high time of the serial clock, read only by a check
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_ff <= 6'h00;
        end else if (!sck_ff) begin
            hi_cnt_ff <= 6'h00;
        end else begin
            hi_cnt_ff <= hi_cnt_ff + 6'h01;
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
    assign rx = rx_ff;
    assign sck = sck_ff;
    assign cs_n = ~busy_ff;
    assign mosi = sh_ff[FRAME_W-1];

    a_sck_high: assert property (@(posedge clock) disable iff (!arst_n)
        $fell(sck_ff) |-> $past(hi_cnt_ff) == half_ff - 6'h01)
        else $error("serial clock high time wrong");

    a_frame_open: assert property (@(posedge clock) disable iff (!arst_n)
        !busy_ff && start |=> !cs_n && !sck_ff ##1 !cs_n)
        else $error("frame did not open on start");
endmodule
`default_nettype wire

// *** eac_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Writing the start bit launches one serial access with current fields
// - Command field picks WRSR, WRITE, READ, WRDI, RDSR or WREN
// - Autoload status sets only after a successful autoload since reset
// - Autoload disable bit blocks autoload; resets to one
// - Clock rate field: 01 divides by 64 (reset), 11 test mode
// - Read-only write-in-progress status bit, reset zero
// - Read-only write-enable-latch status bit, reset zero
// - Two writable block protection bits, reset zero
// - Writable write-protect-enable top bit; bits 14:12 read-only, reset zero, loaded by RDSR
// - Sixteen-bit writable address in low half, reset zero
// - Sixteen-bit data in high half, write source and read result
module eac_controller #(
    parameter logic [15:0] AL_SIGNATURE = 16'h5a5a,
    parameter int AL_WORDS = 4
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [eac_pkg::EAC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic eeprom_sck,
    output logic eeprom_cs_n,
    output logic eeprom_mosi,
    input wire logic eeprom_miso,
    output var eac_pkg::eac_cfg_s cfg_load,
    output logic irq
);
    import eac_pkg::*;

    if (AL_WORDS < 1 || AL_WORDS > 65535) begin : g_chk
        $error("eac_controller: AL_WORDS out of range");
    end

    eac_state_e state_ff, nxt_state;
    eac_cmd_e cmd_ff, acc_cmd_ff, l_cmd;
    logic start_ff, al_stat_ff, al_dis_ff, al_arm_ff;
    logic [1:0] rate_ff;
    logic [7:0] status_ff;
    logic [15:0] addr_ff, data_ff, al_idx_ff, l_addr;
    logic [EAC_INT_W-1:0] int_stat_ff, int_mask_ff, ev;
    logic [31:0] rdata_ff;
    eac_cfg_s cfg_ff;
    logic wr_ctrl, wr_ad, wr_is, wr_im, rd_ctrl, rd_ad, rd_is, rd_im;
    logic al_go, cmd_valid, clr_start, start_rewr, acc_end;
    logic al_ok, al_fail, al_word;
    logic eng_start, eng_busy, eng_done;
    logic [15:0] eng_rx;
    logic [7:0] rx_stat;
    logic [EAC_FRAME_W-1:0] frame;
    logic [5:0] nbits, half;
    logic [15:0] ctrl_word;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_ad = 1'b0;
        wr_is = 1'b0;
        wr_im = 1'b0;
        if (reg_addr == EAC_CTRL_OFS) begin
            wr_ctrl = reg_wr;
        end else if (reg_addr == EAC_ADDR_DATA_OFS) begin
            wr_ad = reg_wr;
        end else if (reg_addr == EAC_INT_STAT_OFS) begin
            wr_is = reg_wr;
        end else if (reg_addr == EAC_INT_MASK_OFS) begin
            wr_im = reg_wr;
        end
    end

    assign rd_ctrl = reg_rd && reg_addr == EAC_CTRL_OFS;
    assign rd_ad = reg_rd && reg_addr == EAC_ADDR_DATA_OFS;
    assign rd_is = reg_rd && reg_addr == EAC_INT_STAT_OFS;
    assign rd_im = reg_rd && reg_addr == EAC_INT_MASK_OFS;

    assign al_go = al_arm_ff && !al_dis_ff;
    assign cmd_valid = cmd_ff != CMD_NONE && cmd_ff != CMD_BAD;
    assign acc_end = state_ff == ST_ACC && eng_done;
    assign start_rewr = wr_ctrl && reg_wdata[EAC_START_BIT];
    assign rx_stat = eng_rx[7:0];
    assign al_word = state_ff == ST_AL_WORD && eng_done;
    assign al_ok = al_word && al_idx_ff == 16'(AL_WORDS);
    assign al_fail = state_ff == ST_AL_SIG && eng_done
        && eng_rx != AL_SIGNATURE;
    // A start with an unusable command completes at once, sending nothing
    assign clr_start = acc_end || (state_ff == ST_IDLE && !al_go
        && start_ff && !cmd_valid);

    // Sequencer: autoload has priority; start waits until it finishes
    always_comb begin
        nxt_state = state_ff;
        eng_start = 1'b0;
        l_cmd = CMD_READ;
        l_addr = 16'h0000;
        case (state_ff)
            ST_IDLE: begin
                if (al_go) begin
                    eng_start = 1'b1;
                    nxt_state = ST_AL_SIG;
                end else if (start_ff && cmd_valid) begin
                    eng_start = 1'b1;
                    l_cmd = cmd_ff;
                    l_addr = addr_ff;
                    nxt_state = ST_ACC;
                end
            end
            ST_AL_SIG: begin
                if (eng_done && !al_fail) begin
                    eng_start = 1'b1;
                    l_addr = 16'h0001;
                    nxt_state = ST_AL_WORD;
                end else if (eng_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_AL_WORD: begin
                if (al_word && !al_ok) begin
                    eng_start = 1'b1;
                    l_addr = al_idx_ff + 16'h0001;
                end else if (al_ok) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ACC: begin
                if (eng_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Frame is opcode first, then address, then data, most significant first
    always_comb begin
        frame = '0;
        nbits = EAC_BITS_OP;
        case (l_cmd)
            CMD_WRSR: begin
                frame = {5'h00, l_cmd, status_ff, 24'h000000};
                nbits = EAC_BITS_STAT;
            end
            CMD_WRITE: begin
                frame = {5'h00, l_cmd, l_addr, data_ff};
                nbits = EAC_BITS_DATA;
            end
            CMD_READ: begin
                frame = {5'h00, l_cmd, l_addr, 16'h0000};
                nbits = EAC_BITS_DATA;
            end
            CMD_RDSR: begin
                frame = {5'h00, l_cmd, 32'h00000000};
                nbits = EAC_BITS_STAT;
            end
            default: begin
                frame = {5'h00, l_cmd, 32'h00000000};
                nbits = EAC_BITS_OP;
            end
        endcase
    end

    // Reserved rate codes fall back to the divide-by-64 rate
    assign half = (rate_ff == EAC_RATE_TEST) ? EAC_TEST_HALF
        : EAC_DIV64_HALF;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            acc_cmd_ff <= CMD_NONE;
        end else begin
            state_ff <= nxt_state;
            if (eng_start && state_ff == ST_IDLE && !al_go) begin
                acc_cmd_ff <= cmd_ff;
            end
        end
    end

    // Control fields; a new start in the finishing cycle is kept
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            start_ff <= EAC_CTRL_RST[EAC_START_BIT];
            cmd_ff <= eac_cmd_e'(EAC_CTRL_RST[EAC_CMD_LSB +: 3]);
            al_dis_ff <= EAC_CTRL_RST[EAC_AL_DIS_BIT];
            rate_ff <= EAC_CTRL_RST[EAC_RATE_LSB +: 2];
        end else begin
            if (clr_start) begin
                start_ff <= 1'b0;
            end
            if (start_rewr) begin
                start_ff <= 1'b1;
            end
            if (wr_ctrl) begin
                cmd_ff <= eac_cmd_e'(reg_wdata[EAC_CMD_LSB +: 3]);
                al_dis_ff <= reg_wdata[EAC_AL_DIS_BIT];
                rate_ff <= reg_wdata[EAC_RATE_LSB +: 2];
            end
        end
    end

    // Autoload runs once per reset, as soon as it is allowed
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            al_arm_ff <= 1'b1;
            al_stat_ff <= EAC_CTRL_RST[EAC_AL_STAT_BIT];
            al_idx_ff <= 16'h0000;
        end else begin
            if (state_ff == ST_AL_SIG && eng_done) begin
                al_idx_ff <= 16'h0001;
            end else if (al_word && !al_ok) begin
                al_idx_ff <= al_idx_ff + 16'h0001;
            end
            if (al_fail || al_ok) begin
                al_arm_ff <= 1'b0;
            end
            if (al_ok) begin
                al_stat_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff.vld <= al_word;
            if (al_word) begin
                cfg_ff.addr <= al_idx_ff - 16'h0001;
                cfg_ff.data <= eng_rx;
            end
        end
    end

    // Status byte: software writes only the protect bits, RDSR loads all
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_ff <= EAC_CTRL_RST[EAC_STAT_LSB +: 8];
        end else if (acc_end && acc_cmd_ff == CMD_RDSR) begin
            status_ff <= rx_stat;
        end else if (wr_ctrl) begin
            status_ff <= (status_ff & ~EAC_STAT_WR_MASK)
                | (reg_wdata[EAC_STAT_LSB +: 8] & EAC_STAT_WR_MASK);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff <= EAC_ADDR_RST;
            data_ff <= EAC_DATA_RST;
        end else begin
            if (wr_ad) begin
                addr_ff <= reg_wdata[15:0];
            end
            if (acc_end && acc_cmd_ff == CMD_READ) begin
                data_ff <= eng_rx;
            end else if (wr_ad) begin
                data_ff <= reg_wdata[31:16];
            end
        end
    end

    assign ev[EAC_INT_ACC] = clr_start;
    assign ev[EAC_INT_AL] = al_ok || al_fail;

    // Event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            int_stat_ff <= '0;
            int_mask_ff <= '0;
        end else begin
            int_stat_ff <= (int_stat_ff
                & ~(wr_is ? reg_wdata[EAC_INT_W-1:0] : '0)) | ev;
            if (wr_im) begin
                int_mask_ff <= reg_wdata[EAC_INT_W-1:0];
            end
        end
    end

    assign ctrl_word = {status_ff, rate_ff, al_dis_ff, al_stat_ff,
        cmd_ff, start_ff};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_ctrl) begin
            rdata_ff <= {16'h0000, ctrl_word};
        end else if (rd_ad) begin
            rdata_ff <= {data_ff, addr_ff};
        end else if (rd_is) begin
            rdata_ff <= {{(32-EAC_INT_W){1'b0}}, int_stat_ff};
        end else if (rd_im) begin
            rdata_ff <= {{(32-EAC_INT_W){1'b0}}, int_mask_ff};
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq = |(int_stat_ff & int_mask_ff);
    assign cfg_load = cfg_ff;

    eac_shifter #(
        .FRAME_W(EAC_FRAME_W),
        .RX_W(16)
    ) u_shifter (
        .clock(clock),
        .arst_n(arst_n),
        .start(eng_start),
        .frame(frame),
        .nbits(nbits),
        .half(half),
        .busy(eng_busy),
        .done(eng_done),
        .rx(eng_rx),
        .sck(eeprom_sck),
        .cs_n(eeprom_cs_n),
        .mosi(eeprom_mosi),
        .miso(eeprom_miso)
    );

    sequence s_acc_end;
        state_ff == ST_ACC && eng_done;
    endsequence

    sequence s_user_launch;
        state_ff == ST_IDLE && !al_go && start_ff && cmd_valid;
    endsequence

    a_start_clear: assert property (@(posedge clock) disable iff (!arst_n)
        s_acc_end |=> !start_ff || $past(start_rewr))
        else $error("start bit not cleared at end of access");

    a_access_begin: assert property (@(posedge clock) disable iff (!arst_n)
        s_user_launch |=> state_ff == ST_ACC && eng_busy)
        else $error("access did not begin after start");

    a_cmd_opcode: assert property (@(posedge clock) disable iff (!arst_n)
        s_user_launch |-> frame[39:32] == {5'h00, cmd_ff})
        else $error("opcode differs from command field");

    a_read_back: assert property (@(posedge clock) disable iff (!arst_n)
        s_acc_end ##0 acc_cmd_ff == CMD_READ
        |=> data_ff == $past(eng_rx))
        else $error("read data not captured");

    a_status_load: assert property (@(posedge clock) disable iff (!arst_n)
        s_acc_end ##0 acc_cmd_ff == CMD_RDSR
        |=> status_ff == $past(rx_stat))
        else $error("status byte not loaded");

    a_al_success: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(al_stat_ff) |-> $past(state_ff) == ST_AL_WORD)
        else $error("autoload status set without autoload");

    a_al_blocked: assert property (@(posedge clock) disable iff (!arst_n)
        al_dis_ff && state_ff == ST_IDLE
        |=> state_ff != ST_AL_SIG)
        else $error("autoload ran while disabled");

    a_addr_keep: assert property (@(posedge clock) disable iff (!arst_n)
        !wr_ad |=> $stable(addr_ff))
        else $error("address changed without a write");
endmodule
`default_nettype wire

// *** eac_eeprom_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module eac_eeprom_model #(
    parameter logic [15:0] SIG = 16'h5a5a
) (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso
);
    logic [15:0] mem [0:15];
    logic [7:0] sr;
    logic [39:0] sh;
    logic [7:0] op;
    logic [15:0] addr;
    int n;
    initial begin
        sr = 8'h00;
        miso = 1'b0;
        op = 8'h00;
        addr = 16'h0000;
        mem[0] = SIG;
        for (int i = 1; i < 16; i++) begin
            mem[i] = 16'(16'h1111 * i);
        end
    end
    always @(negedge cs_n) begin
        n = 0;
        sh = '0;
    end
    always @(posedge sck) begin
        sh = {sh[38:0], mosi};
        n++;
        if (n == 8) begin
            op = sh[7:0];
        end
        if (n == 24) begin
            addr = sh[15:0];
        end
    end
    // Undriven line toggles so a stale bit never reads as valid
    always @(negedge sck or posedge cs_n) begin
        if (!cs_n && op == 8'h05 && n >= 8 && n < 16) begin
            miso <= sr[15-n];
        end else if (!cs_n && op == 8'h03 && n >= 24 && n < 40) begin
            miso <= mem[addr[3:0]][39-n];
        end else begin
            miso <= ~miso;
        end
    end
    // Writes need the latch; a write stays busy until one status read
    always @(posedge cs_n) begin
        case (op)
            8'h06: sr[1] = 1'b1;
            8'h04: sr[1] = 1'b0;
            8'h01: if (sr[1] && n == 16) sr = {sh[7], 3'h0, sh[3:2], 2'h0};
            8'h02: if (sr[1] && n == 40) begin
                mem[sh[19:16]] = sh[15:0];
                sr[1:0] = 2'h1;
            end
            8'h05: sr[0] = 1'b0;
            default: ;
        endcase
    end
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import eac_pkg::*;
    logic clock, arst_n, reg_wr, reg_rd, sck, cs_n, mosi, miso, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    eac_cfg_s cfg_load;
    logic [1:0] rate;
    logic [7:0] stat;
    logic [15:0] cl_a [0:7];
    logic [15:0] cl_d [0:7];
    int ncl, lowcnt, checks, n_mismatch;
    eac_controller i_dut (.clock(clock), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eeprom_sck(sck),
        .eeprom_cs_n(cs_n), .eeprom_mosi(mosi), .eeprom_miso(miso),
        .cfg_load(cfg_load), .irq(irq));
    eac_eeprom_model i_mem (.sck(sck), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (cs_n === 1'b0) lowcnt++;
        if (cfg_load.vld === 1'b1 && ncl < 8) begin
            cl_a[ncl] = cfg_load.addr;
            cl_d[ncl] = cfg_load.data;
            ncl++;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
    endtask
    task automatic acc(input logic [2:0] cmd);
        logic [31:0] d;
        int i;
        wr(12'h0a0, {16'h0, stat, rate, 1'b1, 1'b0, cmd, 1'b1});
        d = 32'h1;
        for (i = 0; i < 2000 && d[0] !== 1'b0; i++) rd(12'h0a0, d);
        chk("start", d[0], 1'b0);
    endtask
    task automatic t_reset;
        logic [31:0] d;
        rd(12'h0a0, d);
        chk("ctrl_rst", d, 32'h0060);
        rd(12'h0a4, d);
        chk("ad_rst", d, 32'h0);
        rd(12'h0a8, d);
        chk("unmapped", d, 32'h0);
        chk("irq_rst", irq, 1'b0);
        wr(12'h0a4, 32'h1234abcd);
        rd(12'h0a4, d);
        chk("ad_rw", d, 32'h1234abcd);
        wr(12'h0a0, 32'hfff0);
        rd(12'h0a0, d);
        chk("ctrl_rw", d, 32'h8ce0);
        rate = 2'h3;
        stat = 8'h8c;
    endtask
    task automatic t_cmds;
        logic [31:0] d;
        wr(12'h0a4, 32'hbeef0005);
        acc(CMD_WREN);
        acc(CMD_RDSR);
        rd(12'h0a0, d);
        chk("wel", d[9], 1'b1);
        acc(CMD_WRITE);
        acc(CMD_RDSR);
        rd(12'h0a0, d);
        chk("wip", d[9:8], 2'h1);
        acc(CMD_RDSR);
        rd(12'h0a0, d);
        chk("wip_end", d[9:8], 2'h0);
        wr(12'h0a4, 32'h0005);
        acc(CMD_READ);
        rd(12'h0a4, d);
        chk("rdata", d, 32'hbeef0005);
        acc(CMD_WREN);
        acc(CMD_WRDI);
        acc(CMD_RDSR);
        rd(12'h0a0, d);
        chk("wrdi", d[9], 1'b0);
        acc(CMD_WREN);
        acc(CMD_WRSR);
        stat = 8'h00;
        acc(CMD_RDSR);
        rd(12'h0a0, d);
        chk("wrsr", d[15:8], 8'h8c);
    endtask
    task automatic t_rate;
        rate = 2'h1;
        lowcnt = 0;
        acc(CMD_WREN);
        chk("div64", lowcnt, 8 * 64);
        rate = 2'h3;
        lowcnt = 0;
        acc(CMD_WREN);
        chk("divtest", lowcnt, 8 * 4);
        rate = 2'h2;
        lowcnt = 0;
        acc(CMD_WREN);
        chk("div_rsvd", lowcnt, 8 * 64);
        lowcnt = 0;
        acc(CMD_BAD);
        chk("bad_cmd", lowcnt, 0);
    endtask
    task automatic t_irq;
        logic [31:0] d;
        rd(12'h1f0, d);
        chk("int_stat", d[0], 1'b1);
        chk("irq_masked", irq, 1'b0);
        wr(12'h1f4, 32'h1);
        chk("irq_on", irq, 1'b1);
        wr(12'h1f0, 32'h1);
        chk("irq_off", irq, 1'b0);
        rd(12'h1f0, d);
        chk("int_clr", d[0], 1'b0);
    endtask
    task automatic t_al(input logic ok);
        logic [31:0] d;
        int i;
        ncl = 0;
        wr(12'h0a0, 32'h00c0);
        d = 32'h0;
        for (i = 0; i < 2000 && d[1] !== 1'b1; i++) rd(12'h1f0, d);
        chk("al_event", d[1], 1'b1);
        rd(12'h0a0, d);
        chk("al_ok", d[4], ok);
        chk("al_n", ncl, ok ? 4 : 0);
        for (i = 0; i < ncl; i++) begin
            chk("al_a", cl_a[i], i);
            chk("al_d", cl_d[i], 16'h1111 * (i + 1));
        end
    endtask
    initial begin
        #3000000;
        n_mismatch++;
        final_report;
    end
    initial begin
        arst_n = 1'b0;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rate = 2'h1;
        stat = 8'h00;
        ncl = 0;
        lowcnt = 0;
        checks = 0;
        n_mismatch = 0;
        do_reset;
        t_reset;
        t_cmds;
        t_rate;
        t_irq;
        chk("al_off", ncl, 0);
        t_al(1'b1);
        i_mem.mem[0] = 16'h0000;
        do_reset;
        t_al(1'b0);
        final_report;
    end
endmodule
`default_nettype wire
